// file: hw/rpb_consts.svh
`ifndef RPB_CONSTS_SVH
`define RPB_CONSTS_SVH
// Twelve phases of one oscillator period each make a machine cycle
`define RPB_PH_LAST 4'd11
`define RPB_STATE_LAST 3'd5
// Machine cycles of high reset input needed before internal reset
`define RPB_RST_MCS 2'd2
// Highest internal code address
`define RPB_INT_CODE_TOP 16'h0fff
// Power control register
`define RPB_POWER_CONTROL_REGISTER_IDLE 0
`define RPB_POWER_CONTROL_REGISTER_PD 1
`define RPB_POWER_CONTROL_REGISTER_RST 8'h00
`define RPB_PORT_RST 8'hff
// One-hot phase masks, bit n stands for phase n
`define RPB_ALE_MASK 12'h186
`define RPB_CODE_READ_STROBE_MASK 12'hc71
`define RPB_ADDR_MASK 12'h1c7
// Code byte taken at the end of phases 5 and 11, before the next address drive
`define RPB_CODE_CAP_MASK 12'h820
`define RPB_HALF2_MASK 12'hfc0
`define RPB_HALF1_MASK 12'h03f
`define RPB_ALE_SKIP_B 12'h007
`define RPB_CODE_READ_STROBE_SKIP_A 12'he00
`define RPB_CODE_READ_STROBE_SKIP_B 12'h07f
`define RPB_STB_A 12'hc00
`define RPB_STB_B 12'h00f
`define RPB_MV_ADDR_A 12'h1c0
`define RPB_WDATA_A 12'he00
`define RPB_RD_CAP_PH 4'd3
`endif

// file: hw/rpb_pkg.sv
package rpb_pkg;

  // Power modes
  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_idle = 2'b01,
    mode_pd = 2'b10
  } rpb_mode_t;

  // External bus sequencing, one state per machine cycle
  typedef enum logic [1:0] {
    bus_fetch = 2'b00,
    bus_external_move_instruction_a = 2'b01,
    bus_external_move_instruction_b = 2'b10
  } rpb_bus_t;

  // The four 8-bit ports, as latches or as sampled pins
  typedef struct packed {
    logic [7:0] port3;
    logic [7:0] port2;
    logic [7:0] port1;
    logic [7:0] port0;
  } rpb_port_t;

  // One port's pin drive; oe_n low drives out onto the pin
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } rpb_pin_t;

  // Core request; move fields sampled at the end of each fetch machine cycle, pc used directly
  typedef struct packed {
    logic [15:0] pc;
    logic external_move_instruction_req;
    logic external_move_instruction_wide;
    logic external_move_instruction_write;
    logic [15:0] external_move_instruction_addr;
    logic [7:0] external_move_instruction_wdata;
  } rpb_core_req_t;

endpackage : rpb_pkg

// file: hw/rpb_pin_sync.sv
`timescale 1ns/1ps
module rpb_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input logic clock,
  input logic resetn,
  // Pins and their filtered copies
  input logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts only once the second and third stages agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sync_out[i] <= 1'b0;
      end else if (s2[i] == s3[i]) begin
        sync_out[i] <= s3[i];
      end
    end
  end

endmodule : rpb_pin_sync

// file: hw/rpb_top.sv
// How it works
// R1 - Port zero open-drain; latched ones float
// R2 - Port zero carries address then data
// R3 - Port two drives high address byte
// R4 - Narrow external moves keep port two latch
// R5 - Ports one to three quasi-bidirectional
// R6 - Port three alternate functions, bits one, six and seven
// R7 - Address strobe at osc/6, one skipped
// R8 - Code strobe twice per cycle, externally only
// R9 - Fetch select low forces external code
// R10 - Oscillator divided by two before timing
// R11 - Reset after two machine cycles high
// R12 - Power-on reset held through oscillator start
// R13 - Idle stops CPU, peripherals keep running
// R14 - Interrupt or reset ends idle
// R15 - Power-down stops oscillator; reset ends it
// R16 - Idle pin states: strobes high
// R17 - Power-down pin states: strobes low
// R18 - Mode bits live in power control register
// R19 - Verify: port one in, port zero out
// R20 - Reset sampled per cycle, two highs
`timescale 1ns/1ps
`include "rpb_consts.svh"
module rpb_top (
  // Clock and reset
  input logic clock,
  input logic resetn,
  // Device input pins
  input logic osc_input,
  input logic reset_pin,
  input logic external_fetch_select,
  input logic verify_mode,
  input rpb_pkg::rpb_port_t pins_in,
  // Device output pins
  output logic osc_output,
  output logic ale,
  output logic code_read_strobe_n,
  output rpb_pkg::rpb_pin_t p0,
  output rpb_pkg::rpb_pin_t p1,
  output rpb_pkg::rpb_pin_t p2,
  output rpb_pkg::rpb_pin_t p3,
  // Core requests
  input rpb_pkg::rpb_core_req_t core_req,
  input rpb_pkg::rpb_port_t latches,
  input logic serial_out,
  input logic power_control_register_write,
  input logic [7:0] power_control_register_wdata,
  input logic irq_wake,
  input logic [7:0] verify_byte,
  // Core status
  output logic internal_reset,
  output logic cpu_run,
  output logic osc_enable,
  output logic machine_tick,
  output logic code_valid,
  output logic [7:0] code_byte,
  output logic external_move_instruction_done,
  output logic [7:0] external_move_instruction_rdata,
  output rpb_pkg::rpb_port_t pin_state,
  output logic [7:0] verify_addr,
  output logic [7:0] power_control_register_read,
  output rpb_pkg::rpb_mode_t mode
);

  function automatic rpb_pkg::rpb_pin_t drive(input logic [7:0] v);
    drive = {v, 8'h00};
  endfunction : drive

  // Pullup does the high level, so ones are released
  function automatic rpb_pkg::rpb_pin_t quasi(input logic [7:0] v);
    quasi = {v, v};
  endfunction : quasi

  function automatic rpb_pkg::rpb_pin_t open_drain(input logic [7:0] v);
    open_drain = {8'h00, v};
  endfunction : open_drain

  localparam rpb_pkg::rpb_pin_t PIN_FLOAT = {8'hff, 8'hff};

  // Pin synchronisers
  logic [35:0] raw_pins;
  logic [35:0] sync_pins;
  assign raw_pins = {osc_input, reset_pin, external_fetch_select, verify_mode, pins_in};

  rpb_pin_sync #(
    .W(36)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in(raw_pins),
    .sync_out(sync_pins)
  );

  wire osc_s = sync_pins[35];
  wire rst_s = sync_pins[34];
  wire ea_s = sync_pins[33];
  wire verify_s = sync_pins[32];
  rpb_pkg::rpb_port_t pins_s;
  assign pins_s = sync_pins[31:0];

  // Timing state
  logic osc_q;
  logic div2;
  logic [2:0] state;
  logic [1:0] rst_cnt;
  logic [7:0] power_control_register;
  rpb_pkg::rpb_bus_t bus;
  rpb_pkg::rpb_bus_t next_bus;
  rpb_pkg::rpb_mode_t next_mode;
  logic mv_wide;
  logic mv_write;
  logic [15:0] mv_addr;
  logic [7:0] mv_wdata;

  wire osc_tick = osc_s & ~osc_q & osc_enable;
  wire [3:0] phase = {state, div2};
  wire [11:0] ph_hot = 12'h001 << phase;
  wire mc_end = osc_tick & (phase == `RPB_PH_LAST);
  wire ext_code = ~ea_s | (core_req.pc > `RPB_INT_CODE_TOP); // see R9
  wire in_a = (bus == rpb_pkg::bus_external_move_instruction_a);
  wire in_b = (bus == rpb_pkg::bus_external_move_instruction_b);
  wire is_idle = (mode == rpb_pkg::mode_idle);
  wire is_pd = (mode == rpb_pkg::mode_pd);

  // Decode of the phase masks
  wire ph_half2 = |(ph_hot & `RPB_HALF2_MASK);
  wire ph_half1 = |(ph_hot & `RPB_HALF1_MASK);
  wire mv_span = (in_a & ph_half2) | (in_b & ph_half1);
  wire ale_skip = in_b & |(ph_hot & `RPB_ALE_SKIP_B);
  wire ale_on = |(ph_hot & `RPB_ALE_MASK) & ~ale_skip; // see R7
  wire code_read_strobe_skip = (in_a & |(ph_hot & `RPB_CODE_READ_STROBE_SKIP_A)) | (in_b & |(ph_hot & `RPB_CODE_READ_STROBE_SKIP_B));
  wire code_read_strobe_on = ext_code & |(ph_hot & `RPB_CODE_READ_STROBE_MASK) & ~code_read_strobe_skip; // see R8
  wire strobe_on = (in_a & |(ph_hot & `RPB_STB_A)) | (in_b & |(ph_hot & `RPB_STB_B));
  wire wr_n_int = ~(strobe_on & mv_write);
  wire rd_n_int = ~(strobe_on & ~mv_write);
  wire fetch_addr_on = ext_code & |(ph_hot & `RPB_ADDR_MASK) & ~mv_span;
  wire mv_addr_on = in_a & |(ph_hot & `RPB_MV_ADDR_A);
  wire wdata_a = in_a & |(ph_hot & `RPB_WDATA_A);
  wire mv_data_on = mv_write & (wdata_a | (in_b & ph_half1));
  wire code_cap = osc_tick & code_read_strobe_on & |(ph_hot & `RPB_CODE_CAP_MASK);
  wire rd_cap = osc_tick & in_b & ~mv_write & (phase == `RPB_RD_CAP_PH);

  // Strobe levels per mode
  wire next_ale = internal_reset | is_idle | (~is_pd & ale_on); // see R16 see R17
  wire next_code_read_strobe_n = internal_reset | is_idle | (~is_pd & ~code_read_strobe_on); // see R16 see R17

  // Port zero: idle and power-down float it only for external code
  wire rpb_pkg::rpb_pin_t p0_port = ext_code ? PIN_FLOAT : open_drain(latches.port0); // see R1
  wire rpb_pkg::rpb_pin_t p0_bus;
  assign p0_bus = mv_addr_on ? drive(mv_addr[7:0]) : // see R2
                  mv_data_on ? drive(mv_wdata) :
                  fetch_addr_on ? drive(core_req.pc[7:0]) :
                  (in_a | in_b | ext_code) ? PIN_FLOAT :
                  open_drain(latches.port0);
  wire rpb_pkg::rpb_pin_t next_p0;
  assign next_p0 = internal_reset ? PIN_FLOAT :
                   verify_s ? open_drain(verify_byte) : // see R19
                   (is_idle | is_pd) ? p0_port : // see R16 see R17
                   p0_bus;

  // Port two
  wire rpb_pkg::rpb_pin_t p2_run;
  assign p2_run = (mv_span & mv_wide) ? drive(mv_addr[15:8]) : // see R3
                  (mv_span & ~mv_wide) ? quasi(latches.port2) : // see R4
                  ext_code ? drive(core_req.pc[15:8]) : // see R3
                  quasi(latches.port2);
  wire rpb_pkg::rpb_pin_t next_p2;
  assign next_p2 = internal_reset ? quasi(`RPB_PORT_RST) :
                   is_pd ? quasi(latches.port2) : // see R17
                   (is_idle & ext_code) ? drive(core_req.pc[15:8]) : // see R16
                   is_idle ? quasi(latches.port2) :
                   p2_run;

  // Port one is released during verify so the programmer can drive it
  wire rpb_pkg::rpb_pin_t next_p1;
  assign next_p1 = (internal_reset | verify_s) ? quasi(`RPB_PORT_RST) : quasi(latches.port1);

  // Port three: serial out and strobes share bits 1, 6 and 7
  wire [7:0] p3_alt = {rd_n_int, wr_n_int, 4'hf, serial_out, 1'b1}; // see R6
  wire rpb_pkg::rpb_pin_t next_p3;
  assign next_p3 = internal_reset ? quasi(`RPB_PORT_RST) : quasi(latches.port3 & p3_alt); // see R5

  // Reset sampling once per machine cycle
  wire [1:0] next_rst_cnt = ~rst_s ? 2'd0 :
                            (rst_cnt == `RPB_RST_MCS) ? rst_cnt : rst_cnt + 2'd1;
  wire next_int_reset = (next_rst_cnt == `RPB_RST_MCS); // see R11 see R20

  // A stopped oscillator restarts as soon as reset is asserted
  wire next_osc_enable = ~is_pd | rst_s; // see R15

  // Bus sequencing, advancing at machine cycle ends
  always_comb begin
    next_bus = bus;
    case (bus)
      rpb_pkg::bus_fetch: begin
        if (core_req.external_move_instruction_req && mode == rpb_pkg::mode_run) begin
          next_bus = rpb_pkg::bus_external_move_instruction_a;
        end
      end
      rpb_pkg::bus_external_move_instruction_a: begin
        next_bus = rpb_pkg::bus_external_move_instruction_b;
      end
      rpb_pkg::bus_external_move_instruction_b: begin
        next_bus = rpb_pkg::bus_fetch;
      end
      default: begin
        next_bus = rpb_pkg::bus_fetch;
      end
    endcase
  end

  // Entry to idle or power-down waits for the cycle end so the instruction completes
  always_comb begin
    next_mode = mode;
    case (mode)
      rpb_pkg::mode_run: begin
        if (mc_end && bus == rpb_pkg::bus_fetch && !core_req.external_move_instruction_req) begin
          if (power_control_register[`RPB_POWER_CONTROL_REGISTER_PD]) begin
            next_mode = rpb_pkg::mode_pd; // see R15 see R18
          end else if (power_control_register[`RPB_POWER_CONTROL_REGISTER_IDLE]) begin
            next_mode = rpb_pkg::mode_idle; // see R13 see R18
          end
        end
      end
      rpb_pkg::mode_idle: begin
        if (irq_wake) begin
          next_mode = rpb_pkg::mode_run; // see R14
        end
      end
      rpb_pkg::mode_pd: begin
        next_mode = rpb_pkg::mode_pd;
      end
      default: begin
        next_mode = rpb_pkg::mode_run;
      end
    endcase
  end

  // Divide-by-two first, so input duty cycle never matters
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      osc_q <= 1'b0;
      div2 <= 1'b0;
      state <= 3'd0;
    end else begin
      osc_q <= osc_s;
      if (osc_tick) begin
        div2 <= ~div2; // see R10
        if (div2) begin
          state <= (state == `RPB_STATE_LAST) ? 3'd0 : state + 3'd1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_cnt <= 2'd0;
      internal_reset <= 1'b1;
    end else if (mc_end) begin
      rst_cnt <= next_rst_cnt;
      internal_reset <= next_int_reset; // see R20
    end
  end

  // Hardware reset puts every mode back to run, as at power-on
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode <= rpb_pkg::mode_run;
      bus <= rpb_pkg::bus_fetch;
    end else if (internal_reset) begin
      mode <= rpb_pkg::mode_run; // see R14 see R15
      bus <= rpb_pkg::bus_fetch;
    end else begin
      mode <= next_mode;
      if (mc_end) begin
        bus <= next_bus;
      end
    end
  end

  // Software write wins over the wake clear; the core cannot write while idle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      power_control_register <= `RPB_POWER_CONTROL_REGISTER_RST;
    end else if (internal_reset) begin
      power_control_register <= `RPB_POWER_CONTROL_REGISTER_RST;
    end else if (power_control_register_write) begin
      power_control_register <= power_control_register_wdata; // see R18
    end else if (is_idle && irq_wake) begin
      power_control_register[`RPB_POWER_CONTROL_REGISTER_IDLE] <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mv_wide <= 1'b0;
      mv_write <= 1'b0;
      mv_addr <= 16'h0000;
      mv_wdata <= 8'h00;
    end else if (mc_end && bus == rpb_pkg::bus_fetch) begin
      mv_wide <= core_req.external_move_instruction_wide;
      mv_write <= core_req.external_move_instruction_write;
      mv_addr <= core_req.external_move_instruction_addr;
      mv_wdata <= core_req.external_move_instruction_wdata;
    end
  end

  // Pin outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ale <= 1'b1;
      code_read_strobe_n <= 1'b1;
      p0 <= PIN_FLOAT;
      p1 <= {`RPB_PORT_RST, `RPB_PORT_RST};
      p2 <= {`RPB_PORT_RST, `RPB_PORT_RST};
      p3 <= {`RPB_PORT_RST, `RPB_PORT_RST};
      osc_output <= 1'b1;
      osc_enable <= 1'b1;
    end else begin
      ale <= next_ale;
      code_read_strobe_n <= next_code_read_strobe_n;
      p0 <= next_p0;
      p1 <= next_p1;
      p2 <= next_p2;
      p3 <= next_p3;
      osc_output <= osc_enable ? ~osc_s : 1'b1;
      osc_enable <= next_osc_enable;
    end
  end

  // Core-side status
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpu_run <= 1'b0;
      machine_tick <= 1'b0;
      code_valid <= 1'b0;
      code_byte <= 8'h00;
      external_move_instruction_done <= 1'b0;
      external_move_instruction_rdata <= 8'h00;
      pin_state <= '0;
      verify_addr <= 8'h00;
      power_control_register_read <= `RPB_POWER_CONTROL_REGISTER_RST;
    end else begin
      cpu_run <= ~internal_reset & (mode == rpb_pkg::mode_run); // see R13
      machine_tick <= mc_end;
      code_valid <= code_cap;
      if (code_cap) begin
        code_byte <= pins_s.port0;
      end
      external_move_instruction_done <= mc_end & in_b;
      if (rd_cap) begin
        external_move_instruction_rdata <= pins_s.port0;
      end
      pin_state <= pins_s;
      verify_addr <= pins_s.port1; // see R19
      power_control_register_read <= power_control_register;
    end
  end

endmodule : rpb_top

// file: test/rpb_checker.sv
`timescale 1ns/1ps
module rpb_checker (
  // Clock and reset
  input logic clock,
  input logic resetn,
  // Pins
  input logic reset_pin,
  input logic external_fetch_select,
  input logic verify_mode,
  input logic ale,
  input logic code_read_strobe_n,
  input rpb_pkg::rpb_pin_t p0,
  input rpb_pkg::rpb_pin_t p1,
  // Core side
  input rpb_pkg::rpb_core_req_t core_req,
  input rpb_pkg::rpb_port_t latches,
  input logic power_control_register_write,
  input logic [7:0] power_control_register_wdata,
  input logic irq_wake,
  input logic [7:0] verify_byte,
  input logic internal_reset,
  input logic [7:0] power_control_register_read,
  input rpb_pkg::rpb_mode_t mode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Counts past the pin synchronisers before judging the strobe
  logic [7:0] int_cnt;
  wire run_m = mode == rpb_pkg::mode_run;
  wire idle_m = mode == rpb_pkg::mode_idle;
  wire pd_m = mode == rpb_pkg::mode_pd;
  wire int_code = external_fetch_select && core_req.pc <= 16'h0fff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn || !int_code) begin
      int_cnt <= 8'h00;
    end else if (int_cnt != 8'hff) begin
      int_cnt <= int_cnt + 8'h01;
    end
  end
  sequence verify_held;
    (verify_mode && $stable(verify_byte) && !internal_reset)[*6];
  endsequence
  sequence quasi_held;
    (!verify_mode && !internal_reset && $stable(latches.port1))[*6];
  endsequence
  int_strobe_a: assert property (
    int_cnt > 8'h28 && !pd_m && !$past(pd_m) |-> code_read_strobe_n)
    else $error("code strobe during internal fetch");
  rst_pins_a: assert property (
    internal_reset && $past(internal_reset) |-> ale && code_read_strobe_n && p0.oe_n == 8'hff)
    else $error("pins not idle in reset");
  ale_rate_a: assert property (
    $rose(ale) && run_m && !internal_reset && !core_req.external_move_instruction_req
      |-> ##[47:49] ($rose(ale) || !run_m || internal_reset))
    else $error("address strobe rate wrong");
  power_control_register_wr_a: assert property (
    power_control_register_write && !internal_reset && !reset_pin |-> ##2 power_control_register_read == $past(power_control_register_wdata, 2))
    else $error("power control write lost");
  quasi_p1_a: assert property (quasi_held |-> p1.oe_n == latches.port1)
    else $error("port one drive wrong");
  verify_p0_a: assert property (
    verify_held |-> p0.oe_n == verify_byte && p0.out == 8'h00 && p1.oe_n == 8'hff)
    else $error("verify drive wrong");
  idle_wake_a: assert property (idle_m && irq_wake |-> ##[1:200] run_m)
    else $error("idle not left on wake");
  pd_hold_a: assert property ((!reset_pin && pd_m)[*8] |=> pd_m)
    else $error("power-down left without reset");
  idle_pins_a: assert property (idle_m && $past(idle_m) |-> ale && code_read_strobe_n)
    else $error("idle strobe levels wrong");
  pd_pins_a: assert property (
    pd_m && $past(pd_m) && !internal_reset |-> !ale && !code_read_strobe_n)
    else $error("power-down strobe levels wrong");
endmodule : rpb_checker

bind rpb_top rpb_checker chk_u (.clock, .resetn, .reset_pin, .external_fetch_select,
  .verify_mode, .ale, .code_read_strobe_n, .p0, .p1, .core_req, .latches, .power_control_register_write,
  .power_control_register_wdata, .irq_wake, .verify_byte, .internal_reset, .power_control_register_read, .mode);

// file: test/rpb_ext_mem.sv
`timescale 1ns/1ps
module rpb_ext_mem (
  // Clock
  input logic clock,
  // Device pins
  input logic ale,
  input logic code_read_strobe_n,
  input rpb_pkg::rpb_pin_t p0,
  input rpb_pkg::rpb_pin_t p1,
  input rpb_pkg::rpb_pin_t p2,
  input rpb_pkg::rpb_pin_t p3,
  input logic verify_mode,
  input logic [7:0] p1_ext,
  // Wire levels and captured traffic
  output rpb_pkg::rpb_port_t pins_in,
  output logic [15:0] mv_addr,
  output logic [7:0] wr_data
);
  logic flip = 1'b0;
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;
  logic [15:0] addr = 16'h0000;
  wire rd_n = p3.oe_n[7] | p3.out[7];
  wire wr_n = p3.oe_n[6] | p3.out[6];
  // Released bus shows a changing pattern, never the last value
  // Programmer pullups win during verify, whatever the strobes do
  wire [7:0] p0_drv = verify_mode ? 8'hff :
    !code_read_strobe_n ? addr[7:0] ^ addr[15:8] ^ 8'h3c :
    !rd_n ? addr[7:0] ^ 8'hc3 : {8{flip}};
  assign pins_in.port0 = (p0.oe_n & p0_drv) | (~p0.oe_n & p0.out);
  assign pins_in.port1 = (p1.oe_n | p1.out) & p1_ext;
  assign pins_in.port2 = p2.oe_n | p2.out;
  assign pins_in.port3 = p3.oe_n | p3.out;
  always_ff @(posedge clock) begin
    flip <= ~flip;
    rd_q <= rd_n;
    wr_q <= wr_n;
    // Transparent latch: address and strobe drop on the same clock
    if (ale) begin
      addr <= {pins_in.port2, pins_in.port0};
    end
    if ((rd_q && !rd_n) || (wr_q && !wr_n)) begin
      mv_addr <= addr;
    end
    if (!wr_q && wr_n) begin
      wr_data <= pins_in.port0;
    end
  end
endmodule : rpb_ext_mem

// file: test/tb_rpb_top.sv
`timescale 1ns/1ps
module tb_rpb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic osc_input = 1'b0;
  logic reset_pin = 1'b1;
  logic esel = 1'b1;
  logic verify_mode = 1'b0;
  logic [7:0] p1_ext = 8'hff;
  rpb_pkg::rpb_core_req_t req = '0;
  rpb_pkg::rpb_port_t latches = 32'hffff_ffff;
  logic serial_out = 1'b1;
  logic power_control_register_write = 1'b0;
  logic [7:0] power_control_register_wdata = 8'h00;
  logic irq_wake = 1'b0;
  logic [7:0] verify_byte = 8'hff;
  logic ale, strobe_n, internal_reset, cpu_run, osc_enable, code_valid, external_move_instruction_done;
  logic [7:0] code_byte, external_move_instruction_rdata, verify_addr, power_control_register_read, wr_data;
  logic [15:0] mv_addr;
  rpb_pkg::rpb_pin_t p0, p1, p2, p3;
  rpb_pkg::rpb_port_t pins_in, pin_state;
  rpb_pkg::rpb_mode_t mode;
  int error_cnt = 0;
  int n_tests = 0;
  int n_ale, n_stb, n_code, n_bad, n_done;
  always #5 clock = ~clock;
  // Oscillator period of eight clocks gives 96 clocks per machine cycle
  always #40 osc_input = ~osc_input;
  // Request leaves once the data strobe shows, so no second move follows
  always @(negedge clock) if (!(p3.oe_n[7] | p3.out[7]) || !(p3.oe_n[6] | p3.out[6]))
    req.external_move_instruction_req <= 1'b0;
  rpb_top dut_u (.clock(clock), .resetn(resetn), .osc_input(osc_input), .reset_pin(reset_pin),
    .external_fetch_select(esel), .verify_mode(verify_mode), .pins_in(pins_in),
    .osc_output(), .ale(ale), .code_read_strobe_n(strobe_n), .p0(p0), .p1(p1), .p2(p2),
    .p3(p3), .core_req(req), .latches(latches), .serial_out(serial_out),
    .power_control_register_write(power_control_register_write), .power_control_register_wdata(power_control_register_wdata), .irq_wake(irq_wake),
    .verify_byte(verify_byte), .internal_reset(internal_reset), .cpu_run(cpu_run),
    .osc_enable(osc_enable), .machine_tick(), .code_valid(code_valid), .code_byte(code_byte),
    .external_move_instruction_done(external_move_instruction_done), .external_move_instruction_rdata(external_move_instruction_rdata), .pin_state(pin_state),
    .verify_addr(verify_addr), .power_control_register_read(power_control_register_read), .mode(mode));
  rpb_ext_mem mem_u (.clock(clock), .ale(ale), .code_read_strobe_n(strobe_n), .p0(p0),
    .p1(p1), .p2(p2), .p3(p3), .verify_mode(verify_mode), .p1_ext(p1_ext),
    .pins_in(pins_in), .mv_addr(mv_addr), .wr_data(wr_data));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_mode(input rpb_pkg::rpb_mode_t m, input logic r);
    for (int i = 0; i < 1000; i++) begin
      @(posedge clock);
      #1;
      if (mode === m && internal_reset === r) return;
    end
    chk("wait_mode", {m, r}, {mode, internal_reset});
    give_verdict();
  endtask : wait_mode
  task automatic run_mc(input int n);
    logic a, s;
    {n_ale, n_stb, n_code, n_bad, n_done} = '0;
    a = ale;
    s = strobe_n;
    repeat (n * 96) begin
      @(posedge clock);
      #1;
      n_ale += int'(ale && !a);
      n_stb += int'(s && !strobe_n);
      n_done += int'(external_move_instruction_done === 1'b1);
      if (code_valid === 1'b1) begin
        n_code++;
        n_bad += int'(code_byte !== (req.pc[7:0] ^ req.pc[15:8] ^ 8'h3c));
      end
      a = ale;
      s = strobe_n;
    end
  endtask : run_mc
  task automatic power_control_register(input logic [7:0] v);
    @(negedge clock);
    power_control_register_write = 1'b1;
    power_control_register_wdata = v;
    @(negedge clock);
    power_control_register_write = 1'b0;
  endtask : power_control_register
  task automatic t_ports();
    @(negedge clock);
    latches[23:0] = 24'h5a_963c;
    serial_out = 1'b0;
    repeat (20) @(negedge clock);
    chk("p0_oe_n", 8'h3c, p0.oe_n);
    chk("p1_pins", 8'h96, pin_state.port1);
    chk("txd_oe_n", 0, p3.oe_n[1]);
    serial_out = 1'b1;
  endtask : t_ports
  task automatic t_fetch();
    logic [15:0] pcs [3] = '{16'h1234, 16'h1000, 16'h0fff};
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      esel = i != 0;
      req.pc = pcs[i];
      run_mc(1);
      run_mc(4);
      chk("ale_pulses", 8, n_ale);
      chk("strobes", i < 2 ? 8 : 0, n_stb);
      chk("code_bytes", i < 2 ? 8 : 0, n_code);
      chk("code_bad", 0, n_bad);
    end
  endtask : t_fetch
  task automatic t_external_move_instruction(input logic wr, input logic wide, input logic [15:0] a);
    @(negedge clock);
    req.external_move_instruction_write = wr;
    req.external_move_instruction_wide = wide;
    req.external_move_instruction_addr = a;
    req.external_move_instruction_wdata = ~a[7:0];
    req.external_move_instruction_req = 1'b1;
    run_mc(4);
    chk("ale_pulses", 7, n_ale);
    chk("strobes", 6, n_stb);
    chk("moves", 1, n_done);
    chk("move_addr", {wide ? a[15:8] : latches.port2, a[7:0]}, mv_addr);
    if (wr) chk("wdata", {8'h00, ~a[7:0]}, wr_data);
    else chk("rdata", a[7:0] ^ 8'hc3, external_move_instruction_rdata);
  endtask : t_external_move_instruction
  task automatic t_reset();
    n_bad = 0;
    @(negedge clock);
    reset_pin = 1'b1;
    repeat (80) @(negedge clock) n_bad += int'(internal_reset !== 1'b0);
    reset_pin = 1'b0;
    chk("reset_early", 0, n_bad);
    repeat (200) @(negedge clock);
    reset_pin = 1'b1;
    wait_mode(rpb_pkg::mode_run, 1'b1);
    @(negedge clock) reset_pin = 1'b0;
    wait_mode(rpb_pkg::mode_run, 1'b0);
  endtask : t_reset
  task automatic t_modes();
    power_control_register(8'h01);
    wait_mode(rpb_pkg::mode_idle, 1'b0);
    // Strobe outputs follow the mode one clock later
    repeat (2) @(negedge clock);
    run_mc(1);
    chk("idle_edges", 0, n_ale + n_stb);
    chk("idle_pins", 2'b11, {ale, strobe_n});
    chk("idle_p2", {req.pc[15:8], 8'h00}, p2);
    chk("idle_cpu", 0, cpu_run);
    chk("power_control_register", 8'h01, power_control_register_read);
    @(negedge clock) irq_wake = 1'b1;
    wait_mode(rpb_pkg::mode_run, 1'b0);
    @(negedge clock) irq_wake = 1'b0;
    power_control_register(8'h02);
    wait_mode(rpb_pkg::mode_pd, 1'b0);
    @(negedge clock) irq_wake = 1'b1;
    run_mc(2);
    chk("pd_edges", 0, n_ale + n_stb);
    chk("pd_pins", 2'b00, {ale, strobe_n});
    chk("pd_p0", 8'hff, p0.oe_n);
    chk("osc_en", 0, osc_enable);
    chk("pd_mode", rpb_pkg::mode_pd, mode);
    @(negedge clock) irq_wake = 1'b0;
    reset_pin = 1'b1;
    wait_mode(rpb_pkg::mode_run, 1'b1);
    repeat (3) @(negedge clock);
    chk("power_control_register_rst", 0, power_control_register_read);
    @(negedge clock) reset_pin = 1'b0;
    wait_mode(rpb_pkg::mode_run, 1'b0);
  endtask : t_modes
  task automatic t_verify();
    @(negedge clock);
    verify_mode = 1'b1;
    verify_byte = 8'ha5;
    p1_ext = 8'h3c;
    repeat (20) @(negedge clock);
    chk("verify_addr", 8'h3c, verify_addr);
    chk("verify_p0", 8'ha5, pin_state.port0);
    verify_mode = 1'b0;
    p1_ext = 8'hff;
  endtask : t_verify
  initial begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    // Reset pin stays high past oscillator start and two machine cycles
    repeat (288) @(negedge clock);
    reset_pin = 1'b0;
    wait_mode(rpb_pkg::mode_run, 1'b0);
    t_ports();
    t_fetch();
    @(negedge clock);
    esel = 1'b0;
    req.pc = 16'h1234;
    t_external_move_instruction(1'b1, 1'b0, 16'h9876);
    t_external_move_instruction(1'b0, 1'b1, 16'h8421);
    t_reset();
    t_modes();
    t_verify();
    give_verdict();
  end
endmodule : tb_rpb_top
